// file: common/ses_pkg.sv
package ses_pkg;

  // ------------------------------------------------------------
  // Register geometry
  // ------------------------------------------------------------
  localparam int SES_W = 8;

  // Event bit positions
  localparam int BIT_OPC = 0;
  localparam int BIT_QRY = 2;
  localparam int BIT_DEV = 3;
  localparam int BIT_EXE = 4;
  localparam int BIT_CMD = 5;
  localparam int BIT_PON = 7;

  // Positions 1 and 6 are never stored
  localparam logic [SES_W-1:0] USED_BITS = 8'hBD;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [SES_W-1:0] MASK_RESET = 8'h00;
  localparam logic [SES_W-1:0] FLAGS_RESET = 8'h80;
  localparam logic [SES_W-1:0] DATA_RESET = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    OPC_IDLE = 1'b0,
    OPC_WAIT = 1'b1
  } ses_opc_t;

  typedef enum logic [1:0] {
    INIT_HOLD = 2'b00,
    INIT_LOAD = 2'b01,
    INIT_DONE = 2'b10
  } ses_init_t;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [SES_W-1:0] ses_used(input logic [SES_W-1:0] v);
    ses_used = v & USED_BITS;
  endfunction

endpackage

// file: common/ses_flag_if.sv
`timescale 1ns/10ps
interface ses_flag_if #(
  parameter int W = 8
);
  // Event pulses to latch
  logic [W-1:0] set_vec;
  // Clear every latched flag
  logic clr;
  // Latched flags
  logic [W-1:0] flags;

  modport owner (
    input set_vec,
    input clr,
    output flags
  );

  modport user (
    output set_vec,
    output clr,
    input flags
  );
endinterface

// file: design/ses_event_latch.sv
`timescale 1ns/10ps
module ses_event_latch #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Flag carrier
  ses_flag_if.owner flg
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (W != ses_pkg::SES_W)
  begin : g_bad_width
    $error("ses_event_latch: W must equal the event register width");
  end

  // ------------------------------------------------------------
  // Flag storage
  // ------------------------------------------------------------
  logic [W-1:0] flags;
  wire logic [W-1:0] kept;
  wire logic [W-1:0] next_flags;

  // Set wins over a clear in the same cycle
  assign kept = flg.clr ? '0 : flags;
  assign next_flags = ses_pkg::ses_used(kept | flg.set_vec);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      flags <= ses_pkg::FLAGS_RESET;
    else
      flags <= next_flags;
  end

  assign flg.flags = flags;

endmodule // ses_event_latch

// file: design/ses_top.sv
`timescale 1ns/10ps
module ses_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Common commands from the parser
  input wire logic mask_wr,
  input wire logic [7:0] mask_wdata,
  input wire logic mask_rd,
  input wire logic flags_rd,
  input wire logic clear_status,
  input wire logic opc_cmd,
  // Power-on clear setting and retained mask
  input wire logic pon_clear_en,
  input wire logic [7:0] mask_retained,
  // Execution state
  input wire logic exec_idle,
  // Error detectors
  input wire logic err_command,
  input wire logic err_execution,
  input wire logic err_device,
  input wire logic err_query_empty,
  input wire logic err_query_unread,
  input wire logic err_query_full,
  // Query answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // Status to the status byte logic
  output logic summary,
  output logic [7:0] mask_now,
  output logic [7:0] flags_now,
  output logic opc_pending
);

  // ------------------------------------------------------------
  // Local declarations
  // ------------------------------------------------------------
  localparam int W = ses_pkg::SES_W;

  // Flags cross to the latch in one bundle
  ses_flag_if #(.W(W)) flg ();

  // Stored state
  logic [W-1:0] mask;
  logic [W-1:0] flags_q;
  logic [W-1:0] rsp_data_q;
  logic rsp_valid_q;
  ses_pkg::ses_opc_t opc_state;
  ses_pkg::ses_init_t init_state;

  // Next values
  logic [W-1:0] next_mask;
  logic [W-1:0] next_rsp_data;
  logic next_rsp_valid;
  ses_pkg::ses_opc_t next_opc_state;
  ses_pkg::ses_init_t next_init_state;

  // Decoded strobes and words
  wire logic init_load;
  wire logic [W-1:0] written_mask;
  wire logic [W-1:0] retained_mask;
  wire logic query_err;
  logic opc_done;
  wire logic [W-1:0] event_pulses;
  wire logic flags_clear;
  wire logic rsp_take;
  wire logic [W-1:0] rsp_pick;
  wire logic [W-1:0] enabled_events;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------

  if (ses_pkg::BIT_PON >= W)
  begin : g_bad_pon
    $error("ses_top: power-on bit lies outside the event register");
  end

  if (!ses_pkg::USED_BITS[ses_pkg::BIT_OPC])
  begin : g_bad_opc
    $error("ses_top: completion bit sits on an unused position");
  end

  if (!ses_pkg::USED_BITS[ses_pkg::BIT_PON])
  begin : g_bad_pon_pos
    $error("ses_top: power-on bit sits on an unused position");
  end

  if ((ses_pkg::USED_BITS & ses_pkg::MASK_RESET) != ses_pkg::MASK_RESET)
  begin : g_bad_mask_reset
    $error("ses_top: mask reset value sets an unused position");
  end

  if ((ses_pkg::USED_BITS & ses_pkg::FLAGS_RESET) != ses_pkg::FLAGS_RESET)
  begin : g_bad_flags_reset
    $error("ses_top: flag reset value sets an unused position");
  end

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------

  // Word with one event position driven by a pulse
  function automatic logic [W-1:0] event_at(
    input int pos,
    input logic hit
  );
    logic [W-1:0] word;
    word = '0;
    word[pos] = hit;
    event_at = word;
  endfunction

  // Query answer: a mask read wins over an event read
  function automatic logic [W-1:0] answer_word(
    input logic sel_mask,
    input logic [W-1:0] mask_word,
    input logic [W-1:0] flag_word
  );
    answer_word = sel_mask ? mask_word : flag_word;
  endfunction

  // ------------------------------------------------------------
  // Power-on mask handling
  // ------------------------------------------------------------

  // Reload happens on the second edge after reset; a mask query
  // issued before then still sees the reset value
  always_comb
  begin
    next_init_state = init_state;
    case (init_state)
      ses_pkg::INIT_HOLD:
        next_init_state = ses_pkg::INIT_LOAD;
      ses_pkg::INIT_LOAD:
        next_init_state = ses_pkg::INIT_DONE;
      ses_pkg::INIT_DONE:
        next_init_state = ses_pkg::INIT_DONE;
      default:
        next_init_state = ses_pkg::INIT_DONE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      init_state <= ses_pkg::INIT_HOLD;
    else
      init_state <= next_init_state;
  end

  // With the clear setting off, the retained mask returns at power on
  assign init_load = (init_state == ses_pkg::INIT_LOAD) && !pon_clear_en;
  assign retained_mask = ses_pkg::ses_used(mask_retained);

  // ------------------------------------------------------------
  // Enable mask
  // ------------------------------------------------------------

  assign written_mask = ses_pkg::ses_used(mask_wdata);
  // A host write in the reload cycle wins
  assign next_mask = mask_wr ? written_mask
    : (init_load ? retained_mask : mask);

  // Clear-status never reaches this register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mask <= ses_pkg::MASK_RESET;
    else
      mask <= next_mask;
  end

  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------

  // Any of the three query faults raises one flag
  assign query_err = err_query_empty
    | err_query_unread
    | err_query_full;

  assign event_pulses = event_at(ses_pkg::BIT_CMD, err_command)
    | event_at(ses_pkg::BIT_EXE, err_execution)
    | event_at(ses_pkg::BIT_DEV, err_device)
    | event_at(ses_pkg::BIT_QRY, query_err)
    | event_at(ses_pkg::BIT_OPC, opc_done);

  // Reading the flags or clear-status empties the register
  assign flags_clear = flags_rd | clear_status;

  assign flg.set_vec = event_pulses;
  assign flg.clr = flags_clear;
  assign flags_q = flg.flags;

  // ------------------------------------------------------------
  // Event latch
  // ------------------------------------------------------------

  ses_event_latch #(
    .W(W)
  ) ses_event_latch_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flg(flg)
  );

  // ------------------------------------------------------------
  // Operation complete tracking
  // ------------------------------------------------------------

  // Waits for the execution engine to drain after the command;
  // a repeat command in the finishing cycle keeps the wait going
  always_comb
  begin
    next_opc_state = opc_state;
    opc_done = 1'b0;
    case (opc_state)
      ses_pkg::OPC_IDLE:
      begin
        if (opc_cmd)
          next_opc_state = ses_pkg::OPC_WAIT;
      end
      ses_pkg::OPC_WAIT:
      begin
        if (exec_idle)
        begin
          opc_done = 1'b1;
          next_opc_state = opc_cmd ? ses_pkg::OPC_WAIT
            : ses_pkg::OPC_IDLE;
        end
      end
      default:
        next_opc_state = ses_pkg::OPC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      opc_state <= ses_pkg::OPC_IDLE;
    else
      opc_state <= next_opc_state;
  end

  // ------------------------------------------------------------
  // Query answer
  // ------------------------------------------------------------

  // The flags are sampled for the answer on the edge that clears them
  assign rsp_take = mask_rd | flags_rd;
  assign rsp_pick = answer_word(mask_rd, mask, flags_q);
  assign next_rsp_valid = rsp_take;
  // The last answer is held until the next query
  assign next_rsp_data = rsp_take ? rsp_pick : rsp_data_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= ses_pkg::DATA_RESET;
    end
    else
    begin
      rsp_valid_q <= next_rsp_valid;
      rsp_data_q <= next_rsp_data;
    end
  end

  // ------------------------------------------------------------
  // Status outputs
  // ------------------------------------------------------------

  // Unused positions are zero in both words, so they never count
  assign enabled_events = flags_q & mask;
  assign summary = |enabled_events;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign mask_now = mask;
  assign flags_now = flags_q;
  assign opc_pending = (opc_state == ses_pkg::OPC_WAIT);

endmodule // ses_top

// file: tb/ses_host.sv
`timescale 1ns/10ps
module ses_host (
  // Clock and answer
  input wire logic clk_sys,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  // Commands
  output logic [7:0] mask_wdata,
  output logic mask_wr,
  output logic flags_rd,
  output logic mask_rd,
  output logic clear_status,
  output logic opc_cmd
);
  initial {opc_cmd, clear_status, mask_rd, flags_rd, mask_wr} = 5'h00;
  initial mask_wdata = 8'h00;
  // One-cycle command; a query then waits a bounded time for its answer
  task automatic cmd(input logic [4:0] c, input logic [7:0] v,
    output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    {opc_cmd, clear_status, mask_rd, flags_rd, mask_wr} = c;
    mask_wdata = v;
    @(negedge clk_sys);
    {opc_cmd, clear_status, mask_rd, flags_rd, mask_wr} = 5'h00;
    mask_wdata = ~v;
    while (c[2:1] != 2'h0 && rsp_valid !== 1'b1 && n < 8)
    begin
      @(negedge clk_sys);
      n++;
    end
    d = rsp_data;
  endtask
endmodule // ses_host

// file: tb/ses_top_assertions.sv
`timescale 1ns/10ps
module ses_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic err_command,
  input wire logic err_execution,
  input wire logic err_device,
  input wire logic err_query_full,
  input wire logic flags_rd,
  input wire logic clear_status,
  input wire logic summary,
  input wire logic [7:0] mask_now,
  input wire logic [7:0] flags_now
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_unused_zero: assert property (((flags_now | mask_now) & 8'h42) == 0)
    else $error("unused");
  a_cmd_err: assert property (err_command |-> ##[1:2] flags_now[5])
    else $error("cmd");
  a_exe_err: assert property (err_execution |-> ##[1:2] flags_now[4])
    else $error("exe");
  a_dev_err: assert property (err_device |-> ##[1:2] flags_now[3])
    else $error("dev");
  a_qry_err: assert property (err_query_full |-> ##[1:2] flags_now[2])
    else $error("qry");
  a_rd_clear: assert property (flags_rd |-> ##[1:3] flags_now == 8'h00)
    else $error("rd");
  a_cls_keep: assert property (clear_status |=> $stable(mask_now))
    else $error("cls");
  a_sum_on: assert property (
    |(flags_now & mask_now) |-> ##[0:1] summary) else $error("sum");
endmodule // ses_chk
bind ses_top ses_chk ses_chk_inst (.*);

// file: tb/ses_top_tb.sv
`timescale 1ns/10ps
module ses_top_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, exec_idle = 1'b0, pon_clear_en = 1'b1;
  logic err_command = 1'b0, err_execution = 1'b0, err_device = 1'b0;
  logic err_query_empty = 1'b0, err_query_unread = 1'b0, err_query_full = 1'b0;
  logic mask_wr, mask_rd, flags_rd, clear_status, opc_cmd, rsp_valid;
  logic summary, opc_pending;
  logic [7:0] mask_retained = 8'hFF, mask_wdata, rsp_data, mask_now;
  logic [7:0] flags_now, d;
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  ses_host ses_host_inst (.*);
  ses_top ses_top_inst (.*);
  task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run;
    end
  end
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    ses_host_inst.cmd(5'h04, 8'h00, d);
    chk("mask", d, 8'h00);
    ses_host_inst.cmd(5'h02, 8'h00, d);
    chk("flags", d, 8'h80);
    ses_host_inst.cmd(5'h01, 8'hFF, d);
    ses_host_inst.cmd(5'h04, 8'h00, d);
    chk("mask", d, 8'hBD);
    for (int i = 0; i < 7; i++)
    begin
      @(negedge clk_sys);
      {err_query_full, err_query_unread, err_query_empty, err_device,
        err_execution, err_command} = 6'h01 << i;
      @(negedge clk_sys);
      {err_query_full, err_query_unread, err_query_empty, err_device,
        err_execution, err_command} = 6'h00;
      if (i == 6)
        break;
      ses_host_inst.cmd(5'h02, 8'h00, d);
      chk("err", d, i < 3 ? 8'h20 >> i : 8'h04);
    end
    exec_idle = 1'b1;
    ses_host_inst.cmd(5'h10, 8'h00, d);
    chk("pend", {7'h00, opc_pending}, 8'h01);
    repeat (3) @(negedge clk_sys);
    ses_host_inst.cmd(5'h08, 8'h00, d);
    chk("cls", flags_now, 8'h00);
    chk("keep", mask_now, 8'hBD);
    chk("sum0", {7'h00, summary}, 8'h00);
    ses_host_inst.cmd(5'h10, 8'h00, d);
    repeat (3) @(negedge clk_sys);
    chk("sum1", {7'h00, summary}, 8'h01);
    ses_host_inst.cmd(5'h02, 8'h00, d);
    chk("opc", d, 8'h01);
    chk("idle", {7'h00, opc_pending}, 8'h00);
    chk("sum2", {7'h00, summary}, 8'h00);
    pon_clear_en = 1'b0;
    mask_retained = 8'h52;
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    ses_host_inst.cmd(5'h04, 8'h00, d);
    chk("retain", d, 8'h10);
    ses_host_inst.cmd(5'h02, 8'h00, d);
    chk("pon", d, 8'h80);
    complete_run;
  end
endmodule // ses_top_tb
